// ### include/cgm_pkg.sv
// Purpose: Constants and carriers of the clock generator mode block
// Assumes: APB register access, 32-bit data, one register per word
// Notes: Offsets and field layouts are this block's own
// Behaviour
// RULE_01 - Reserved test bits are written as zeros
// RULE_02 - Bit five fine-tunes range for 32.768 kHz
// RULE_03 - Range status follows synchronised range in effect
// RULE_04 - Range status reads zero in low-power, PLL modes
// RULE_05 - Range select writes ignored under low-power or PLL
// RULE_06 - Untuned FLL factor is 512 or 1024
// RULE_07 - Fine-tuned FLL factor is 608 or 1216
// RULE_08 - Nine states, only permitted transitions taken
// RULE_09 - Reset mode is FLL engaged internal
// RULE_10 - Source 00, external, FLL gives FLL engaged external
// RULE_11 - Source 01, internal, FLL, awake gives FLL bypassed
// RULE_12 - Source 10, external, FLL, awake gives FLL bypassed
// RULE_13 - Source 00, external, PLL gives PLL engaged
// RULE_14 - Source 10, external, PLL, awake gives PLL bypassed
// RULE_15 - FLL modes: debug clock from FLL, PLL off
// RULE_16 - PLL modes: debug clock oscillator/2, else FLL off
// RULE_17 - Loop locks to factor times scaled external reference
// RULE_18 - Software keeps bus clock within device maximum
// RULE_19 - Low-power internal mode, debug falls back to bypass
// RULE_20 - Low-power external mode, both loops disabled
// RULE_21 - Source change waits until new clock available
// RULE_22 - Bus clock keeps old range until new starts
// RULE_23 - Undefined setting combinations keep the current mode
package cgm_pkg;
    localparam logic [7:0] CGM_CTRL_OFS = 8'h00;
    localparam logic [7:0] CGM_RANGE_OFS = 8'h04;
    localparam logic [7:0] CGM_STAT_OFS = 8'h08;
    // Control word field positions
    localparam int CGM_CS_LSB = 0;
    localparam int CGM_IREF_BIT = 2;
    localparam int CGM_LOOP_BIT = 3;
    localparam int CGM_LOWPWR_BIT = 4;
    localparam int CGM_REFDIV_LSB = 5;
    localparam int CGM_XDIV_BIT = 8;
    localparam int CGM_MULT_LSB = 9;
    // Range word field positions
    localparam int CGM_FINE_BIT = 5;
    localparam int CGM_RANGE_BIT = 0;
    // Reset values
    localparam logic [1:0] CGM_CS_RST = 2'h0;
    localparam logic CGM_IREF_RST = 1'b1;
    localparam logic [2:0] CGM_REFDIV_RST = 3'h0;
    localparam logic [3:0] CGM_MULT_RST = 4'h1;
    // Clock source codes
    localparam logic [1:0] CGM_CS_LOOP = 2'h0;
    localparam logic [1:0] CGM_CS_INT = 2'h1;
    localparam logic [1:0] CGM_CS_EXT = 2'h2;
    // Loop factors
    localparam logic [10:0] CGM_FLL_LO = 11'h200;
    localparam logic [10:0] CGM_FLL_HI = 11'h400;
    localparam logic [10:0] CGM_FLL_FLO = 11'h260;
    localparam logic [10:0] CGM_FLL_FHI = 11'h4c0;
    localparam logic [5:0] CGM_PLL_MAX = 6'h28;
    localparam logic [3:0] CGM_MULT_TOP = 4'ha;

    typedef enum logic [3:0] {
        CGM_FE_INT = 4'h0, CGM_FB_INT = 4'h1, CGM_FB_EXT = 4'h2,
        CGM_FE_EXT = 4'h3, CGM_LB_INT = 4'h4, CGM_LB_EXT = 4'h5,
        CGM_PB_EXT = 4'h6, CGM_PE_EXT = 4'h7, CGM_STOP = 4'hc
    } cgm_mode_t;

    typedef struct packed {
        logic [1:0] out_src;
        logic fll_en;
        logic pll_en;
        logic dbg_from_fll;
        logic dbg_from_dco_half;
    } cgm_loop_ctl_t;

    typedef struct packed {
        logic [2:0] ref_div;
        logic extra_divide_by_32;
        logic [5:0] pll_factor;
        logic [10:0] fll_factor;
    } cgm_scale_t;
endpackage

// ### logic/cgm_mode_ctrl.sv
// Purpose: Clock generator mode selection and oscillator range control
// Assumes: Availability, debug, stop and range-ack inputs are asynchronous
// Notes: APB slave answers with zero wait states
`timescale 1ns/100ps
module cgm_mode_ctrl #(
    parameter int ADDR_W = 8
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [2:0] i_src_avail,
    input wire logic i_debug_active,
    input wire logic i_stop,
    input wire logic i_dco_range_ack,
    output cgm_pkg::cgm_mode_t o_mode,
    output cgm_pkg::cgm_loop_ctl_t o_loop_ctl,
    output cgm_pkg::cgm_scale_t o_scale,
    output logic o_dco_range_req,
    output logic o_dco_fine_tune_max,
    output logic o_dco_range_active
);
    if (ADDR_W < 8) begin : g_chk
        $error("ADDR_W must be at least 8");
    end

    localparam int NSYNC = 6;

    logic [NSYNC-1:0] sync0_q;
    logic [NSYNC-1:0] sync1_q;
    logic [2:0] avail_s;
    logic dbg_s;
    logic stop_s;
    logic ack_s;

    logic [1:0] clock_source_select_q;
    logic internal_ref_select_q;
    logic loop_select_q;
    logic low_power_bit_q;
    logic [2:0] reference_divider_q;
    logic extra_divide_by_32_q;
    logic [3:0] pll_multiplier_q;
    logic dco_range_select_q;
    logic dco_fine_tune_max_q;
    logic range_active_q;
    cgm_pkg::cgm_mode_t mode_q;
    cgm_pkg::cgm_mode_t mode_d;
    cgm_pkg::cgm_mode_t prev_q;
    cgm_pkg::cgm_mode_t prev_d;
    cgm_pkg::cgm_loop_ctl_t ctl_q;
    cgm_pkg::cgm_scale_t scale_q;
    logic [31:0] prdata_q;

    // Every asynchronous input passes two flops before use
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            sync0_q <= '0;
            sync1_q <= '0;
        end else begin
            sync0_q <= {i_dco_range_ack, i_stop, i_debug_active, i_src_avail};
            sync1_q <= sync0_q;
        end
    end
    assign avail_s = sync1_q[2:0];
    assign dbg_s = sync1_q[3];
    assign stop_s = sync1_q[4];
    assign ack_s = sync1_q[5];

    // Decode used by mode selection and by clock-source status
    function automatic logic [1:0] src_of(input cgm_pkg::cgm_mode_t m);
        case (m)
            cgm_pkg::CGM_FE_INT, cgm_pkg::CGM_FE_EXT,
            cgm_pkg::CGM_PE_EXT: src_of = cgm_pkg::CGM_CS_LOOP;
            cgm_pkg::CGM_FB_INT,
            cgm_pkg::CGM_LB_INT: src_of = cgm_pkg::CGM_CS_INT;
            cgm_pkg::CGM_FB_EXT, cgm_pkg::CGM_PB_EXT,
            cgm_pkg::CGM_LB_EXT: src_of = cgm_pkg::CGM_CS_EXT;
            default: src_of = 2'h3;
        endcase
    endfunction

    function automatic logic is_fll(input cgm_pkg::cgm_mode_t m);
        is_fll = (m == cgm_pkg::CGM_FE_INT) || (m == cgm_pkg::CGM_FE_EXT) ||
                 (m == cgm_pkg::CGM_FB_INT) || (m == cgm_pkg::CGM_FB_EXT);
    endfunction

    // Edges of the mode graph, taken in both directions
    function automatic logic edge_ok(input cgm_pkg::cgm_mode_t a,
                                     input cgm_pkg::cgm_mode_t b);
        logic [7:0] p;
        p = {a, b};
        case (p)
            {cgm_pkg::CGM_FE_INT, cgm_pkg::CGM_FE_EXT},
            {cgm_pkg::CGM_FE_INT, cgm_pkg::CGM_FB_INT},
            {cgm_pkg::CGM_FE_INT, cgm_pkg::CGM_FB_EXT},
            {cgm_pkg::CGM_FE_EXT, cgm_pkg::CGM_FB_INT},
            {cgm_pkg::CGM_FE_EXT, cgm_pkg::CGM_FB_EXT},
            {cgm_pkg::CGM_FB_INT, cgm_pkg::CGM_FB_EXT},
            {cgm_pkg::CGM_FB_INT, cgm_pkg::CGM_LB_INT},
            {cgm_pkg::CGM_FB_EXT, cgm_pkg::CGM_LB_EXT},
            {cgm_pkg::CGM_FB_EXT, cgm_pkg::CGM_PB_EXT},
            {cgm_pkg::CGM_PB_EXT, cgm_pkg::CGM_LB_EXT},
            {cgm_pkg::CGM_PB_EXT, cgm_pkg::CGM_PE_EXT}: edge_ok = 1'b1;
            default: edge_ok = 1'b0;
        endcase
    endfunction

    // Target mode from the settings; tgt_valid low means hold
    logic tgt_valid;
    cgm_pkg::cgm_mode_t tgt;
    logic lp_eff;
    assign lp_eff = low_power_bit_q && !dbg_s; // [RULE_19] [RULE_20]
    always_comb begin
        tgt_valid = 1'b0;
        tgt = mode_q;
        case (clock_source_select_q)
            cgm_pkg::CGM_CS_LOOP: begin
                tgt_valid = 1'b1;
                if (internal_ref_select_q && !loop_select_q) begin
                    tgt = cgm_pkg::CGM_FE_INT; // [RULE_09]
                end else if (!internal_ref_select_q && !loop_select_q) begin
                    tgt = cgm_pkg::CGM_FE_EXT; // [RULE_10]
                end else if (!internal_ref_select_q) begin
                    tgt = cgm_pkg::CGM_PE_EXT; // [RULE_13]
                end else begin
                    tgt_valid = 1'b0; // [RULE_23]
                end
            end
            cgm_pkg::CGM_CS_INT: begin
                tgt_valid = internal_ref_select_q && !loop_select_q;
                tgt = lp_eff ? cgm_pkg::CGM_LB_INT
                             : cgm_pkg::CGM_FB_INT; // [RULE_11] [RULE_19]
            end
            cgm_pkg::CGM_CS_EXT: begin
                tgt_valid = !internal_ref_select_q;
                if (lp_eff) begin
                    tgt = cgm_pkg::CGM_LB_EXT; // [RULE_20]
                end else if (loop_select_q) begin
                    tgt = cgm_pkg::CGM_PB_EXT; // [RULE_14]
                end else begin
                    tgt = cgm_pkg::CGM_FB_EXT; // [RULE_12]
                end
            end
            default: tgt_valid = 1'b0; // [RULE_23]
        endcase
    end

    // Outside stop, a mode is left only along a graph edge, once its clock runs
    logic tgt_go;
    assign tgt_go = tgt_valid && (tgt != mode_q) &&
                    (edge_ok(mode_q, tgt) || edge_ok(tgt, mode_q)) &&
                    avail_s[src_of(tgt)]; // [RULE_08] [RULE_21]

    always_comb begin
        mode_d = mode_q;
        prev_d = prev_q;
        if (mode_q == cgm_pkg::CGM_STOP) begin
            if (!stop_s) begin
                mode_d = prev_q;
            end
        end else if (stop_s) begin
            mode_d = cgm_pkg::CGM_STOP;
            prev_d = mode_q;
        end else if (tgt_go) begin
            mode_d = tgt; // [RULE_08]
        end
    end

    // Loop enables and debug clock source per mode
    cgm_pkg::cgm_loop_ctl_t ctl_d;
    always_comb begin
        ctl_d = '0;
        ctl_d.out_src = src_of(mode_q);
        case (mode_q)
            cgm_pkg::CGM_FE_INT, cgm_pkg::CGM_FE_EXT,
            cgm_pkg::CGM_FB_INT, cgm_pkg::CGM_FB_EXT: begin
                ctl_d.fll_en = 1'b1; // [RULE_15]
                ctl_d.dbg_from_fll = 1'b1;
            end
            cgm_pkg::CGM_PE_EXT, cgm_pkg::CGM_PB_EXT: begin
                ctl_d.pll_en = 1'b1; // [RULE_16]
                ctl_d.dbg_from_dco_half = dbg_s;
                ctl_d.fll_en = dbg_s;
            end
            // Low-power modes keep their output source, loops off
            default: ctl_d.fll_en = 1'b0; // [RULE_19] [RULE_20]
        endcase
        if (mode_q == cgm_pkg::CGM_STOP) begin
            ctl_d.out_src = 2'h3;
        end
    end

    // FLL factor of the range really in effect
    function automatic logic [10:0] fll_factor(input logic rng,
                                               input logic fine);
        case ({fine, rng})
            2'b00: fll_factor = cgm_pkg::CGM_FLL_LO; // [RULE_06]
            2'b01: fll_factor = cgm_pkg::CGM_FLL_HI; // [RULE_06]
            2'b10: fll_factor = cgm_pkg::CGM_FLL_FLO; // [RULE_07] [RULE_02]
            default: fll_factor = cgm_pkg::CGM_FLL_FHI; // [RULE_07]
        endcase
    endfunction

    // Reserved multiplier codes saturate; code zero multiplies by zero
    logic [5:0] pll_factor;
    assign pll_factor = (pll_multiplier_q > cgm_pkg::CGM_MULT_TOP)
        ? cgm_pkg::CGM_PLL_MAX : {pll_multiplier_q, 2'b00};

    cgm_pkg::cgm_scale_t scale_d;
    always_comb begin
        scale_d.ref_div = reference_divider_q; // [RULE_17]
        scale_d.extra_divide_by_32 = extra_divide_by_32_q && !loop_select_q;
        scale_d.pll_factor = pll_factor;
        scale_d.fll_factor = fll_factor(range_active_q, dco_fine_tune_max_q);
    end

    // APB decode
    logic acc;
    logic wr;
    logic hit_ctrl;
    logic hit_range;
    logic hit_stat;
    logic mapped;
    logic range_wr_ok;
    logic range_status;
    assign acc = i_psel && i_penable;
    assign wr = acc && i_pwrite;
    assign hit_ctrl = i_paddr == ADDR_W'(cgm_pkg::CGM_CTRL_OFS);
    assign hit_range = i_paddr == ADDR_W'(cgm_pkg::CGM_RANGE_OFS);
    assign hit_stat = i_paddr == ADDR_W'(cgm_pkg::CGM_STAT_OFS);
    assign mapped = hit_ctrl || hit_range || hit_stat;
    assign range_wr_ok = !low_power_bit_q && !loop_select_q; // [RULE_05]
    // Status only counts in FLL modes and only after the ack crosses
    assign range_status = range_active_q && is_fll(mode_q); // [RULE_03] [RULE_04]

    logic [31:0] rd_ctrl;
    logic [31:0] rd_range;
    logic [31:0] rd_stat;
    assign rd_ctrl = {19'h0, pll_multiplier_q, extra_divide_by_32_q,
                      reference_divider_q, low_power_bit_q, loop_select_q,
                      internal_ref_select_q, clock_source_select_q};
    // Test bits always read back zero
    assign rd_range = {26'h0, dco_fine_tune_max_q, 4'h0, range_status};
    assign rd_stat = {26'h0, src_of(mode_q), mode_q};

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            clock_source_select_q <= cgm_pkg::CGM_CS_RST; // [RULE_09]
            internal_ref_select_q <= cgm_pkg::CGM_IREF_RST;
            loop_select_q <= 1'b0;
            low_power_bit_q <= 1'b0;
            reference_divider_q <= cgm_pkg::CGM_REFDIV_RST;
            extra_divide_by_32_q <= 1'b0;
            pll_multiplier_q <= cgm_pkg::CGM_MULT_RST;
        end else if (wr && hit_ctrl) begin
            clock_source_select_q <= i_pwdata[cgm_pkg::CGM_CS_LSB +: 2];
            internal_ref_select_q <= i_pwdata[cgm_pkg::CGM_IREF_BIT];
            loop_select_q <= i_pwdata[cgm_pkg::CGM_LOOP_BIT];
            low_power_bit_q <= i_pwdata[cgm_pkg::CGM_LOWPWR_BIT];
            reference_divider_q <= i_pwdata[cgm_pkg::CGM_REFDIV_LSB +: 3];
            extra_divide_by_32_q <= i_pwdata[cgm_pkg::CGM_XDIV_BIT];
            pll_multiplier_q <= i_pwdata[cgm_pkg::CGM_MULT_LSB +: 4];
        end
    end

    // Test bits are not stored, so stray ones have no effect
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            dco_fine_tune_max_q <= 1'b0;
            dco_range_select_q <= 1'b0;
        end else if (wr && hit_range) begin
            dco_fine_tune_max_q <= i_pwdata[cgm_pkg::CGM_FINE_BIT]; // [RULE_02] [RULE_01]
            if (range_wr_ok) begin
                dco_range_select_q <= i_pwdata[cgm_pkg::CGM_RANGE_BIT]; // [RULE_05]
            end
        end
    end

    // The oscillator acks the new range once it runs; until then the
    // bus clock stays on the old range
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            range_active_q <= 1'b0;
            mode_q <= cgm_pkg::CGM_FE_INT; // [RULE_09]
            prev_q <= cgm_pkg::CGM_FE_INT;
            ctl_q <= '0;
            scale_q <= '0;
            prdata_q <= '0;
        end else begin
            range_active_q <= ack_s; // [RULE_22] [RULE_03]
            mode_q <= mode_d;
            prev_q <= prev_d;
            ctl_q <= ctl_d;
            scale_q <= scale_d;
            if (i_psel && !i_penable && !i_pwrite) begin
                prdata_q <= hit_ctrl ? rd_ctrl
                          : hit_range ? rd_range
                          : hit_stat ? rd_stat : 32'h0;
            end
        end
    end

    assign o_prdata = prdata_q;
    assign o_pready = 1'b1;
    assign o_pslverr = acc && !mapped;
    assign o_mode = mode_q;
    assign o_loop_ctl = ctl_q;
    assign o_scale = scale_q;
    assign o_dco_range_req = dco_range_select_q;
    assign o_dco_fine_tune_max = dco_fine_tune_max_q;
    assign o_dco_range_active = range_active_q; // [RULE_22]
endmodule

// ### tb/cgm_mode_ctrl_asserts.sv
// Purpose: Port checks for the clock generator mode block
// Assumes: Control word reset value 0x204, APB zero wait
// Notes: Helper copy of control tracks APB writes
`timescale 1ns/100ps
module cgm_mode_ctrl_asserts #(
    parameter int ADDR_W = 8
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire cgm_pkg::cgm_mode_t o_mode,
    input wire cgm_pkg::cgm_loop_ctl_t o_loop_ctl,
    input wire cgm_pkg::cgm_scale_t o_scale,
    input wire logic o_dco_range_req,
    input wire logic o_dco_fine_tune_max,
    input wire logic o_dco_range_active
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    logic [31:0] ctrl_q;
    wire acc = i_psel && i_penable;
    wire [7:0] a8 = 8'(i_paddr);
    wire mapped = a8 inside {8'h00, 8'h04, 8'h08};
    wire locked = ctrl_q[cgm_pkg::CGM_LOWPWR_BIT] |
        ctrl_q[cgm_pkg::CGM_LOOP_BIT];
    wire wd0 = i_pwdata[0];
    wire wd5 = i_pwdata[5];
    wire fll_mode = o_mode inside {cgm_pkg::CGM_FE_INT, cgm_pkg::CGM_FB_INT,
        cgm_pkg::CGM_FB_EXT, cgm_pkg::CGM_FE_EXT};
    wire pll_mode = o_mode inside {cgm_pkg::CGM_PB_EXT, cgm_pkg::CGM_PE_EXT};
    wire lp_mode = o_mode inside {cgm_pkg::CGM_LB_INT, cgm_pkg::CGM_LB_EXT};
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            ctrl_q <= 32'h00000204;
        end else if (acc && i_pwrite && a8 == cgm_pkg::CGM_CTRL_OFS) begin
            ctrl_q <= i_pwdata;
        end
    end
    // Moves are legal in either direction along the mode graph
    function automatic logic legal(input logic [3:0] a, input logic [3:0] b);
        logic [7:0] e = {a, b};
        logic [7:0] r = {b, a};
        return e inside {8'h03, 8'h01, 8'h02, 8'h31, 8'h32, 8'h12, 8'h14,
            8'h25, 8'h26, 8'h65, 8'h67} || r inside {8'h03, 8'h01, 8'h02,
            8'h31, 8'h32, 8'h12, 8'h14, 8'h25, 8'h26, 8'h65, 8'h67}
            || a == 4'hc || b == 4'hc;
    endfunction
    sequence rng_wr_s;
        acc && i_pwrite && a8 == cgm_pkg::CGM_RANGE_OFS;
    endsequence
    sequence rng_rd_s;
        acc && !i_pwrite && a8 == cgm_pkg::CGM_RANGE_OFS;
    endsequence
    ready_const_a: assert property (o_pready)
        else $error("pready low");
    unmapped_err_a: assert property (acc |-> o_pslverr == !mapped)
        else $error("pslverr wrong for address");
    range_lock_a: assert property (
        rng_wr_s ##0 locked |=> $stable(o_dco_range_req))
        else $error("range select changed while locked");
    range_write_a: assert property (rng_wr_s ##0 !locked |=>
        o_dco_range_req == $past(wd0))
        else $error("range select not stored");
    fine_write_a: assert property (
        rng_wr_s |=> o_dco_fine_tune_max == $past(wd5))
        else $error("fine tune not stored");
    status_read_a: assert property (rng_rd_s |->
        o_prdata[31:6] == 26'h0 && o_prdata[4:1] == 4'h0 &&
        o_prdata[0] == ($past(o_dco_range_active) && $past(fll_mode)))
        else $error("range status read wrong");
    mode_graph_a: assert property (
        o_mode != $past(o_mode) |-> legal($past(o_mode), o_mode))
        else $error("illegal mode move");
    reset_mode_a: assert property (
        $rose(i_resetn) |-> o_mode == cgm_pkg::CGM_FE_INT)
        else $error("mode after reset not fll engaged internal");
    fll_ctl_a: assert property (
        $past(i_resetn) && $past(fll_mode) |->
        o_loop_ctl.fll_en && o_loop_ctl.dbg_from_fll && !o_loop_ctl.pll_en)
        else $error("fll mode enables wrong");
    pll_ctl_a: assert property (
        $past(i_resetn) && $past(pll_mode) |->
        o_loop_ctl.pll_en && !o_loop_ctl.dbg_from_fll)
        else $error("pll mode enables wrong");
    lowpower_ctl_a: assert property (
        $past(i_resetn) && $past(lp_mode) |-> !o_loop_ctl.fll_en &&
        !o_loop_ctl.pll_en && o_loop_ctl.out_src == (($past(o_mode) ==
        cgm_pkg::CGM_LB_INT) ? 2'h1 : 2'h2))
        else $error("low power mode enables wrong");
    factor_a: assert property ($past(i_resetn) |->
        o_scale.fll_factor == ($past(o_dco_fine_tune_max) ?
        ($past(o_dco_range_active) ? 11'h4c0 : 11'h260) :
        ($past(o_dco_range_active) ? 11'h400 : 11'h200)))
        else $error("fll factor wrong");
endmodule
bind cgm_mode_ctrl cgm_mode_ctrl_asserts #(.ADDR_W(ADDR_W)) u_chk (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_mode(o_mode), .o_loop_ctl(o_loop_ctl),
    .o_scale(o_scale), .o_dco_range_req(o_dco_range_req),
    .o_dco_fine_tune_max(o_dco_fine_tune_max),
    .o_dco_range_active(o_dco_range_active));

// ### tb/tb_top.sv
// Purpose: Register and mode sequence bench for the clock generator
// Assumes: Stop request never raised here
// Notes: Waits on mode are bounded; a timeout counts as a mismatch
`timescale 1ns/100ps
module tb_top;
    logic i_mclk = 1'b0;
    logic i_resetn = 1'b0;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, dbg = 1'b0, ack = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [2:0] avail = 3'h7;
    logic pready, pslverr, req, fine, act, err;
    cgm_pkg::cgm_mode_t mode;
    cgm_pkg::cgm_loop_ctl_t ctl;
    cgm_pkg::cgm_scale_t scale;
    int n_errors = 0;
    int samples_checked = 0;
    logic [31:0] rw [4] = '{32'h0, 32'h20, 32'h21, 32'h1};
    logic ra [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    logic [10:0] ff [4] = '{cgm_pkg::CGM_FLL_LO, cgm_pkg::CGM_FLL_FLO,
        cgm_pkg::CGM_FLL_FHI, cgm_pkg::CGM_FLL_HI};
    logic [31:0] mw [6] = '{32'h20a, 32'h202, 32'h200, 32'h204, 32'h205,
        32'h215};
    cgm_pkg::cgm_mode_t mm [6] = '{cgm_pkg::CGM_PB_EXT, cgm_pkg::CGM_FB_EXT,
        cgm_pkg::CGM_FE_EXT, cgm_pkg::CGM_FE_INT, cgm_pkg::CGM_FB_INT,
        cgm_pkg::CGM_LB_INT};
    always #20 i_mclk = ~i_mclk;
    cgm_mode_ctrl u_dut (.i_mclk(i_mclk), .i_resetn(i_resetn),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_src_avail(avail), .i_debug_active(dbg),
        .i_stop(1'b0), .i_dco_range_ack(ack), .o_mode(mode),
        .o_loop_ctl(ctl), .o_scale(scale), .o_dco_range_req(req),
        .o_dco_fine_tune_max(fine), .o_dco_range_active(act));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int i;
        @(posedge i_mclk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_mclk);
        pen <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge i_mclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_errors++;
            $display("mismatch pready expected 1 seen 0");
            print_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a,
        input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task automatic wait_mode(input cgm_pkg::cgm_mode_t m, input int n);
        int i;
        for (i = 0; i < n; i++) begin
            @(posedge i_mclk);
            if (mode === m && n > 12) break;
        end
        chk("mode", 32'(m), 32'(mode));
        if (n > 12 && mode !== m) begin
            print_verdict();
        end
    endtask
    initial begin
        repeat (2) @(posedge i_mclk);
        i_resetn <= 1'b1;
        rdchk("ctrl", 8'h00, 32'h204);
        rdchk("stat", 8'h08, 32'h0);
        rdchk("unmapped", 8'h0c, 32'h0);
        chk("pslverr", 32'h1, 32'(err));
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, 8'h04, rw[k]);
            ack <= ra[k];
            repeat (6) @(posedge i_mclk);
            rdchk("range", 8'h04, (rw[k] & 32'h20) | 32'(ra[k]));
            chk("factor", 32'(ff[k]), 32'(scale.fll_factor));
            chk("fine", 32'(rw[k][5]), 32'(fine));
            chk("act", 32'(ra[k]), 32'(act));
            chk("req", 32'(rw[k][0]), 32'(req));
        end
        $display("test range done");
        avail <= 3'h3;
        apb(1'b1, 8'h00, 32'h202);
        wait_mode(cgm_pkg::CGM_FE_INT, 10);
        avail <= 3'h7;
        wait_mode(cgm_pkg::CGM_FB_EXT, 20);
        rdchk("stat", 8'h08, 32'h22);
        apb(1'b1, 8'h00, 32'h20a);
        wait_mode(cgm_pkg::CGM_PB_EXT, 20);
        rdchk("range", 8'h04, 32'h0);
        apb(1'b1, 8'h04, 32'h20);
        @(posedge i_mclk);
        chk("req", 32'h1, 32'(req));
        apb(1'b1, 8'h00, 32'h21a);
        wait_mode(cgm_pkg::CGM_LB_EXT, 20);
        repeat (2) @(posedge i_mclk);
        chk("ctl", 32'h20, 32'(ctl));
        dbg <= 1'b1;
        wait_mode(cgm_pkg::CGM_PB_EXT, 20);
        repeat (2) @(posedge i_mclk);
        chk("ctl", 32'h2d, 32'(ctl));
        dbg <= 1'b0;
        wait_mode(cgm_pkg::CGM_LB_EXT, 20);
        apb(1'b1, 8'h00, 32'h20a);
        wait_mode(cgm_pkg::CGM_PB_EXT, 20);
        apb(1'b1, 8'h00, 32'h268);
        wait_mode(cgm_pkg::CGM_PE_EXT, 20);
        repeat (2) @(posedge i_mclk);
        chk("ctl", 32'h4, 32'(ctl));
        chk("pll", 32'h4, 32'(scale.pll_factor));
        chk("ref_div", 32'h3, 32'(scale.ref_div));
        apb(1'b1, 8'h00, 32'h20b);
        wait_mode(cgm_pkg::CGM_PE_EXT, 10);
        apb(1'b1, 8'h00, 32'h204);
        wait_mode(cgm_pkg::CGM_PE_EXT, 10);
        for (int j = 0; j < 6; j++) begin
            apb(1'b1, 8'h00, mw[j]);
            wait_mode(mm[j], 20);
        end
        rdchk("range", 8'h04, 32'h20);
        $display("test modes done");
        print_verdict();
    end
endmodule
